// File: flag_synchronizer.sv
// two-stage synchroniser for a vector of independent level flags
`default_nettype none
module flag_synchronizer #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // first stage feeds only the second stage
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stage_one <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule : flag_synchronizer
`default_nettype wire

// File: gateway_regs_pkg.sv
// register map, field positions, keys and timing constants of the gateway status and connection block
`default_nettype none
package gateway_regs_pkg;
    // register addresses
    localparam logic [15:0] ADDR_STATUS         = 16'h100c;
    localparam logic [15:0] ADDR_POLICY         = 16'h1130;
    localparam logic [15:0] ADDR_TIMEOUT        = 16'h1131;
    localparam logic [15:0] ADDR_RESTORE_FIRST  = 16'h113c;
    localparam logic [15:0] ADDR_RESTORE_SECOND = 16'h113d;
    localparam logic [15:0] ADDR_SAVE_FIRST     = 16'h113e;
    localparam logic [15:0] ADDR_SAVE_SECOND    = 16'h113f;
    // sequence keys
    localparam logic [15:0] KEY_RESTORE_FIRST   = 16'h6c6f;
    localparam logic [15:0] KEY_RESTORE_SECOND  = 16'h6164;
    localparam logic [15:0] KEY_SAVE_FIRST      = 16'h7361;
    localparam logic [15:0] KEY_SAVE_SECOND     = 16'h7665;
    // status word bit positions
    localparam int ST_FORCE        = 14;
    localparam int ST_WDOG         = 12;
    localparam int ST_CFG_ERR      = 11;
    localparam int ST_BUS_LOST     = 10;
    localparam int ST_SYS_LOW      = 9;
    localparam int ST_SYS_HIGH     = 8;
    localparam int ST_LOAD_LOW     = 7;
    localparam int ST_CFG_WARN     = 3;
    localparam int ST_DIAG         = 0;
    localparam logic [15:0] ST_USED_MASK = 16'h5f89;
    // flag vector positions of the raw status inputs
    localparam int FL_FORCE        = 0;
    localparam int FL_WDOG         = 1;
    localparam int FL_CFG_ERR      = 2;
    localparam int FL_BUS_LOST     = 3;
    localparam int FL_SYS_LOW      = 4;
    localparam int FL_SYS_HIGH     = 5;
    localparam int FL_LOAD_LOW     = 6;
    localparam int FL_CFG_WARN     = 7;
    localparam int FL_DIAG         = 8;
    localparam int NUM_FLAGS       = 9;
    // connection policy fields and defaults
    localparam int POL_SINGLE      = 0;
    localparam int POL_GRANT       = 1;
    localparam logic [1:0]  POLICY_RESET  = 2'h0;
    localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
    // exception codes
    localparam logic [7:0] EXC_NONE     = 8'h00;
    localparam logic [7:0] EXC_REFUSED  = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
    // timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int TICK_NS         = 1000000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam int WINDOW_S        = 30;
    localparam int WINDOW_TICKS_DEF = WINDOW_S * (1000000000 / TICK_NS);
    // key sequence state
    typedef enum logic {SEQ_IDLE, SEQ_ARMED} seq_state_t;
endpackage : gateway_regs_pkg
`default_nettype wire

// File: gateway_status_connection_control.sv
// status word, connection write policy, idle timeout and keyed restore/save sequences
`default_nettype none
module gateway_status_connection_control
    import gateway_regs_pkg::*;
#(
    parameter int NUM_CONN     = 8,
    parameter int CONN_ID_W    = 3,
    parameter int TICK_CYCLES  = TICK_CYCLES_DEF,
    parameter int WINDOW_TICKS = WINDOW_TICKS_DEF
) (
    input  wire logic                 clk_sys_in,
    input  wire logic                 reset_n_in,
    input  wire logic                 force_active_in,
    input  wire logic                 watchdog_expired_in,
    input  wire logic                 cfg_incompatible_in,
    input  wire logic                 module_bus_lost_in,
    input  wire logic                 system_supply_low_flag_in,
    input  wire logic                 system_supply_high_flag_in,
    input  wire logic                 load_supply_low_flag_in,
    input  wire logic                 cfg_changed_in,
    input  wire logic                 diag_active_in,
    input  wire logic                 req_valid_in,
    input  wire logic                 req_write_in,
    input  wire logic [CONN_ID_W-1:0] req_conn_in,
    input  wire logic [15:0]          req_addr_in,
    input  wire logic [15:0]          req_wdata_in,
    input  wire logic                 conn_open_in,
    input  wire logic                 conn_close_in,
    input  wire logic [CONN_ID_W-1:0] conn_event_id_in,
    output logic                      rsp_valid_out,
    output logic [15:0]               rsp_rdata_out,
    output logic [7:0]                rsp_exception_out,
    output logic                      conn_drop_out,
    output logic [CONN_ID_W-1:0]      conn_drop_id_out,
    output logic                      params_restored_out,
    output logic                      param_store_out,
    output logic [NUM_CONN-1:0]       write_auth_out
);
    localparam int TICK_W = $clog2(TICK_CYCLES + 1);
    localparam int WIN_W  = $clog2(WINDOW_TICKS + 1);

    logic [NUM_FLAGS-1:0] flags_raw;
    logic [NUM_FLAGS-1:0] flags_sync;
    logic [15:0]          status_word,    next_status_word;
    logic [1:0]           policy,         next_policy;
    logic [15:0]          timeout,        next_timeout;
    logic                 next_rsp_valid;
    logic [15:0]          next_rsp_rdata;
    logic [7:0]           next_rsp_exception;
    logic [TICK_W-1:0]    tick_count,     next_tick_count;
    logic                 tick;
    logic [NUM_CONN-1:0]  active,         next_active;
    logic [NUM_CONN-1:0]  next_auth;
    logic [15:0]          idle [NUM_CONN];
    logic [15:0]          next_idle [NUM_CONN];
    logic                 next_drop;
    logic [CONN_ID_W-1:0] next_drop_id;
    logic                 drop_found;
    seq_state_t           seq_state [2];
    seq_state_t           next_seq_state [2];
    logic [WIN_W-1:0]     seq_timer [2];
    logic [WIN_W-1:0]     next_seq_timer [2];
    logic [1:0]           seq_fire;
    logic                 req_wr;
    logic                 holder_any;
    logic                 wr_allowed;

    ////////////////////////////////////////////////////////////////////////////////
    // status inputs come from pins and are synchronised first
    assign flags_raw[FL_FORCE]    = force_active_in;
    assign flags_raw[FL_WDOG]     = watchdog_expired_in;
    assign flags_raw[FL_CFG_ERR]  = cfg_incompatible_in;
    assign flags_raw[FL_BUS_LOST] = module_bus_lost_in;
    assign flags_raw[FL_SYS_LOW]  = system_supply_low_flag_in;
    assign flags_raw[FL_SYS_HIGH] = system_supply_high_flag_in;
    assign flags_raw[FL_LOAD_LOW] = load_supply_low_flag_in;
    assign flags_raw[FL_CFG_WARN] = cfg_changed_in;
    assign flags_raw[FL_DIAG]     = diag_active_in;

    flag_synchronizer #(
        .WIDTH (NUM_FLAGS)
    ) u_flag_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .async_in   (flags_raw),
        .sync_out   (flags_sync)
    );

    // status word assembly, reserved bits left at zero
    always_comb
    begin
        next_status_word              = 16'h0000;
        next_status_word[ST_FORCE]    = flags_sync[FL_FORCE];
        next_status_word[ST_WDOG]     = flags_sync[FL_WDOG];
        next_status_word[ST_CFG_ERR]  = flags_sync[FL_CFG_ERR];
        next_status_word[ST_BUS_LOST] = flags_sync[FL_BUS_LOST];
        next_status_word[ST_SYS_LOW]  = flags_sync[FL_SYS_LOW];
        next_status_word[ST_SYS_HIGH] = flags_sync[FL_SYS_HIGH];
        next_status_word[ST_LOAD_LOW] = flags_sync[FL_LOAD_LOW];
        next_status_word[ST_CFG_WARN] = flags_sync[FL_CFG_WARN];
        next_status_word[ST_DIAG]     = flags_sync[FL_DIAG];
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            status_word <= 16'h0000;
        else
            status_word <= next_status_word;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // millisecond tick shared by idle counters and key windows
    always_comb
    begin
        tick            = (tick_count == TICK_W'(TICK_CYCLES - 1));
        next_tick_count = tick ? '0 : tick_count + TICK_W'(1);
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            tick_count <= '0;
        else
            tick_count <= next_tick_count;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write authorization decision for the current request
    assign req_wr     = req_valid_in && req_write_in;
    assign holder_any = |write_auth_out;
    // free writes without single-writer, else own grant or a free slot
    assign wr_allowed = !policy[POL_SINGLE] || write_auth_out[req_conn_in] || !holder_any;

    // connection table: open, close, idle drop, grant on write
    always_comb
    begin
        next_active  = active;
        next_auth    = write_auth_out;
        next_idle    = idle;
        next_drop    = 1'b0;
        next_drop_id = '0;
        drop_found   = 1'b0;
        if (conn_open_in)
        begin
            next_active[conn_event_id_in] = 1'b1;
            next_idle[conn_event_id_in]   = 16'h0000;
            // immediate grant, limited to the first one in single-writer mode
            next_auth[conn_event_id_in]   = policy[POL_GRANT] && (!policy[POL_SINGLE] || !holder_any);
        end
        if (conn_close_in)
        begin
            next_active[conn_event_id_in] = 1'b0;
            next_auth[conn_event_id_in]   = 1'b0;
        end
        for (int i = 0; i < NUM_CONN; i++)
        begin
            if (tick && active[i] && (idle[i] < timeout))
                next_idle[i] = idle[i] + 16'h0001;
            // a request arriving on the same connection keeps it alive
            if (!drop_found && active[i] && (timeout != 16'h0000) && (idle[i] >= timeout)
                && !(req_valid_in && (req_conn_in == CONN_ID_W'(i))))
            begin
                drop_found     = 1'b1;
                next_drop      = 1'b1;
                next_drop_id   = CONN_ID_W'(i);
                next_active[i] = 1'b0;
                next_auth[i]   = 1'b0;
                next_idle[i]   = 16'h0000;
            end
        end
        if (req_valid_in)
            next_idle[req_conn_in] = 16'h0000;
        if (req_wr && wr_allowed)
            next_auth[req_conn_in] = 1'b1;
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            active           <= '0;
            write_auth_out   <= '0;
            conn_drop_out    <= 1'b0;
            conn_drop_id_out <= '0;
            for (int i = 0; i < NUM_CONN; i++)
                idle[i] <= 16'h0000;
        end
        else
        begin
            active           <= next_active;
            write_auth_out   <= next_auth;
            conn_drop_out    <= next_drop;
            conn_drop_id_out <= next_drop_id;
            idle             <= next_idle;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // keyed sequences: index 0 restores defaults, index 1 requests storage
    always_comb
    begin
        logic [15:0] addr_a;
        logic [15:0] addr_b;
        logic [15:0] key_a;
        logic [15:0] key_b;
        addr_a         = 16'h0000;
        addr_b         = 16'h0000;
        key_a          = 16'h0000;
        key_b          = 16'h0000;
        next_seq_state = seq_state;
        next_seq_timer = seq_timer;
        seq_fire       = 2'h0;
        for (int s = 0; s < 2; s++)
        begin
            addr_a = (s == 0) ? ADDR_RESTORE_FIRST  : ADDR_SAVE_FIRST;
            addr_b = (s == 0) ? ADDR_RESTORE_SECOND : ADDR_SAVE_SECOND;
            key_a  = (s == 0) ? KEY_RESTORE_FIRST   : KEY_SAVE_FIRST;
            key_b  = (s == 0) ? KEY_RESTORE_SECOND  : KEY_SAVE_SECOND;
            if (seq_state[s] == SEQ_ARMED && tick)
                next_seq_timer[s] = seq_timer[s] + WIN_W'(1);
            if (seq_state[s] == SEQ_ARMED && seq_timer[s] >= WIN_W'(WINDOW_TICKS))
                next_seq_state[s] = SEQ_IDLE;
            if (req_wr && wr_allowed && req_addr_in == addr_a)
            begin
                // a right first key arms afresh, a wrong one disarms
                next_seq_state[s] = (req_wdata_in == key_a) ? SEQ_ARMED : SEQ_IDLE;
                next_seq_timer[s] = '0;
            end
            if (req_wr && wr_allowed && req_addr_in == addr_b)
            begin
                case (seq_state[s])
                    SEQ_ARMED: seq_fire[s] = (req_wdata_in == key_b) && (seq_timer[s] < WIN_W'(WINDOW_TICKS));
                    default:   seq_fire[s] = 1'b0;
                endcase
                next_seq_state[s] = SEQ_IDLE;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            seq_state[0]        <= SEQ_IDLE;
            seq_state[1]        <= SEQ_IDLE;
            seq_timer[0]        <= '0;
            seq_timer[1]        <= '0;
            params_restored_out <= 1'b0;
            param_store_out     <= 1'b0;
        end
        else
        begin
            seq_state           <= next_seq_state;
            seq_timer           <= next_seq_timer;
            params_restored_out <= seq_fire[0];
            param_store_out     <= seq_fire[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register access and answer, one cycle after the request
    always_comb
    begin
        next_policy        = policy;
        next_timeout       = timeout;
        next_rsp_valid     = req_valid_in;
        next_rsp_rdata     = 16'h0000;
        next_rsp_exception = EXC_NONE;
        if (req_wr && !wr_allowed)
            next_rsp_exception = EXC_REFUSED;
        else if (req_valid_in)
        begin
            case (req_addr_in)
                ADDR_STATUS:
                    if (req_write_in)
                        next_rsp_exception = EXC_BAD_ADDR;
                    else
                        next_rsp_rdata = status_word;
                ADDR_POLICY:
                    if (req_write_in)
                        next_policy = req_wdata_in[1:0];
                    else
                        next_rsp_rdata = {14'h0, policy};
                ADDR_TIMEOUT:
                    if (req_write_in)
                        next_timeout = req_wdata_in;
                    else
                        next_rsp_rdata = timeout;
                ADDR_RESTORE_FIRST, ADDR_RESTORE_SECOND, ADDR_SAVE_FIRST, ADDR_SAVE_SECOND:
                    next_rsp_rdata = 16'h0000;
                default:
                    next_rsp_exception = EXC_BAD_ADDR;
            endcase
        end
        // restore touches working values only; storage is never requested here
        if (seq_fire[0])
        begin
            next_policy  = POLICY_RESET;
            next_timeout = TIMEOUT_RESET;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            policy            <= POLICY_RESET;
            timeout           <= TIMEOUT_RESET;
            rsp_valid_out     <= 1'b0;
            rsp_rdata_out     <= 16'h0000;
            rsp_exception_out <= EXC_NONE;
        end
        else
        begin
            policy            <= next_policy;
            timeout           <= next_timeout;
            rsp_valid_out     <= next_rsp_valid;
            rsp_rdata_out     <= next_rsp_rdata;
            rsp_exception_out <= next_rsp_exception;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_force_bit;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(flags_sync[FL_FORCE]) |=> status_word[ST_FORCE];
    endproperty
    a_force_bit: assert property (p_force_bit) else $error("force bit not set");

    property p_wdog_bit;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        watchdog_expired_in [*3] |=> status_word[ST_WDOG];
    endproperty
    a_wdog_bit: assert property (p_wdog_bit) else $error("watchdog bit not set");

    property p_bus_lost_bit;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        $fell(flags_sync[FL_BUS_LOST]) |=> !status_word[ST_BUS_LOST];
    endproperty
    a_bus_lost_bit: assert property (p_bus_lost_bit) else $error("bus lost bit stuck");

    property p_reserved_zero;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (status_word & ~ST_USED_MASK) == 16'h0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved status bit set");

    property p_refuse_code;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (req_wr && policy[POL_SINGLE] && holder_any && !write_auth_out[req_conn_in])
            |=> rsp_valid_out && rsp_exception_out == EXC_REFUSED;
    endproperty
    a_refuse_code: assert property (p_refuse_code) else $error("refused write not answered 01h");

    property p_free_write;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (req_wr && !policy[POL_SINGLE]) |=> rsp_exception_out != EXC_REFUSED;
    endproperty
    a_free_write: assert property (p_free_write) else $error("write refused without single-writer");

    property p_grant_kept;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (write_auth_out[0] && !conn_close_in && !conn_open_in && !next_drop) |=> write_auth_out[0];
    endproperty
    a_grant_kept: assert property (p_grant_kept) else $error("authorization lost while connected");

    property p_policy_reserved;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (req_valid_in && !req_write_in && req_addr_in == ADDR_POLICY) |=> rsp_rdata_out[15:2] == 14'h0000;
    endproperty
    a_policy_reserved: assert property (p_policy_reserved) else $error("reserved policy bits read nonzero");

    property p_drop_clears;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        conn_drop_out |-> !active[conn_drop_id_out] && !write_auth_out[conn_drop_id_out];
    endproperty
    a_drop_clears: assert property (p_drop_clears) else $error("dropped connection still active");

    property p_restore_defaults;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        params_restored_out |-> policy == POLICY_RESET && timeout == TIMEOUT_RESET && !param_store_out;
    endproperty
    a_restore_defaults: assert property (p_restore_defaults) else $error("restore left values");

    property p_wrong_key;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        (req_wr && req_addr_in == ADDR_RESTORE_SECOND && req_wdata_in != KEY_RESTORE_SECOND)
            |=> !params_restored_out;
    endproperty
    a_wrong_key: assert property (p_wrong_key) else $error("restore fired on wrong key");
endmodule : gateway_status_connection_control
`default_nettype wire

// File: modbus_client_model.sv
// modbus client model: register requests and connection events
`default_nettype none
module modbus_client_model (
    input  wire logic   clk_sys_in,
    output logic        req_valid_out,
    output logic        req_write_out,
    output logic [2:0]  req_conn_out,
    output logic [15:0] req_addr_out,
    output logic [15:0] req_wdata_out,
    output logic        conn_open_out,
    output logic        conn_close_out,
    output logic [2:0]  conn_event_id_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // all lines quiet at time zero
    initial {req_valid_out, req_write_out, req_conn_out, req_addr_out, req_wdata_out, conn_open_out, conn_close_out,
             conn_event_id_out} = '0;
    // request held to the next falling edge; calls may follow back to back
    task automatic access(input logic wr, input logic [2:0] c, input logic [15:0] a, input logic [15:0] d);
        {req_valid_out, req_write_out, req_conn_out, req_addr_out, req_wdata_out} = {1'b1, wr, c, a, d};
        @(negedge clk_sys_in);
    endtask : access
    // released address and data lines are inverted; a second release in a row shows the stale request again
    task automatic release_bus(input int n);
        {req_valid_out, req_addr_out, req_wdata_out} = {1'b0, ~req_addr_out, ~req_wdata_out};
        repeat (n) @(negedge clk_sys_in);
    endtask : release_bus
    // one-cycle open or close of a connection, bus released first
    task automatic conn_event(input logic op, input logic [2:0] id);
        release_bus(0);
        {conn_open_out, conn_close_out, conn_event_id_out} = {op, ~op, id};
        @(negedge clk_sys_in);
        {conn_open_out, conn_close_out} = 2'h0;
        @(negedge clk_sys_in);
    endtask : conn_event
endmodule : modbus_client_model
`default_nettype wire

// File: test_gateway_status_connection_control.sv
// self-checking bench for the gateway status and connection block
`default_nettype none
module test_gateway_status_connection_control
    import gateway_regs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int WN = 5;
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [8:0]  flags = '0;
    logic        v, w, op_o, cl, rv, drop, rest, store;
    logic [2:0]  c, id, drop_id;
    logic [15:0] a, d, rd, exp_st;
    logic [7:0]  rx, auth;
    int          bad_count = 0;
    int          checked = 0;
    int          n;
    int          pos[9] = '{ST_FORCE, ST_WDOG, ST_CFG_ERR, ST_BUS_LOST, ST_SYS_LOW, ST_SYS_HIGH, ST_LOAD_LOW,
                           ST_CFG_WARN, ST_DIAG};
    // 200 MHz clock
    always #2.5 clk_sys_in = ~clk_sys_in;
    modbus_client_model client_u (.clk_sys_in, .req_valid_out(v), .req_write_out(w), .req_conn_out(c),
        .req_addr_out(a), .req_wdata_out(d), .conn_open_out(op_o), .conn_close_out(cl), .conn_event_id_out(id));
    gateway_status_connection_control #(.TICK_CYCLES(TK), .WINDOW_TICKS(WN)) dut_u (.clk_sys_in, .reset_n_in,
        .force_active_in(flags[FL_FORCE]), .watchdog_expired_in(flags[FL_WDOG]),
        .cfg_incompatible_in(flags[FL_CFG_ERR]), .module_bus_lost_in(flags[FL_BUS_LOST]),
        .system_supply_low_flag_in(flags[FL_SYS_LOW]), .system_supply_high_flag_in(flags[FL_SYS_HIGH]),
        .load_supply_low_flag_in(flags[FL_LOAD_LOW]), .cfg_changed_in(flags[FL_CFG_WARN]),
        .diag_active_in(flags[FL_DIAG]), .req_valid_in(v), .req_write_in(w), .req_conn_in(c), .req_addr_in(a),
        .req_wdata_in(d), .conn_open_in(op_o), .conn_close_in(cl), .conn_event_id_in(id), .rsp_valid_out(rv),
        .rsp_rdata_out(rd), .rsp_exception_out(rx), .conn_drop_out(drop), .conn_drop_id_out(drop_id),
        .params_restored_out(rest), .param_store_out(store), .write_auth_out(auth));
    // count a compare and report a difference
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one access; valid, exception and read data compared together
    task automatic op(input logic wr, input logic [2:0] cn, input logic [15:0] ad, input logic [15:0] dt,
                      input logic [7:0] ex = EXC_NONE, input logic [15:0] ex_rd = '0);
        client_u.access(wr, cn, ad, dt);
        chk("answer", {8'h01, ex, ex_rd}, {7'h00, rv, rx, rd});
    endtask : op
    // verdict and end of run
    task automatic stop_test();
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // main sequence
    initial
    begin
        repeat (8) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        @(negedge clk_sys_in);
        op(0, 0, ADDR_POLICY, '0);
        for (int i = 0; i <= NUM_FLAGS; i++)
        begin
            flags = (i == NUM_FLAGS) ? 9'h1ff : 9'h001 << i;
            exp_st = (i == NUM_FLAGS) ? 16'h5f89 : 16'h0001 << pos[i];
            client_u.release_bus(4);
            op(0, 0, ADDR_STATUS, '0, EXC_NONE, exp_st);
        end
        op(1, 0, ADDR_STATUS, 16'hffff, EXC_BAD_ADDR);
        client_u.conn_event(1, 0);
        client_u.conn_event(1, 1);
        op(1, 0, ADDR_POLICY, 16'hffff);
        op(0, 0, ADDR_POLICY, '0, EXC_NONE, 16'h0003);
        op(1, 1, ADDR_TIMEOUT, '0, EXC_REFUSED);
        chk("auth", 32'h01, {24'h0, auth});
        client_u.conn_event(0, 0);
        op(1, 1, ADDR_TIMEOUT, '0);
        client_u.conn_event(1, 2);
        chk("auth", 32'h02, {24'h0, auth});
        client_u.conn_event(0, 1);
        client_u.conn_event(1, 3);
        chk("auth", 32'h08, {24'h0, auth});
        op(1, 3, ADDR_TIMEOUT, 16'hffff);
        op(1, 3, ADDR_RESTORE_FIRST, KEY_RESTORE_FIRST);
        op(1, 3, ADDR_RESTORE_SECOND, 16'h6165);
        chk("restore and store", 32'h0, {30'h0, rest, store});
        op(1, 3, ADDR_RESTORE_FIRST, KEY_RESTORE_FIRST);
        client_u.release_bus(WN * TK * 2);
        op(1, 3, ADDR_RESTORE_SECOND, KEY_RESTORE_SECOND);
        chk("restore and store", 32'h0, {30'h0, rest, store});
        op(0, 3, ADDR_TIMEOUT, '0, EXC_NONE, 16'hffff);
        op(1, 3, ADDR_RESTORE_FIRST, KEY_RESTORE_FIRST);
        op(1, 3, ADDR_RESTORE_SECOND, KEY_RESTORE_SECOND);
        chk("restore and store", 32'h2, {30'h0, rest, store});
        op(0, 3, ADDR_TIMEOUT, '0);
        op(0, 3, ADDR_POLICY, '0);
        op(1, 3, ADDR_SAVE_FIRST, KEY_SAVE_FIRST);
        op(1, 3, ADDR_SAVE_SECOND, KEY_SAVE_SECOND);
        chk("restore and store", 32'h1, {30'h0, rest, store});
        client_u.conn_event(0, 2);
        client_u.conn_event(0, 3);
        client_u.conn_event(1, 6);
        op(1, 6, ADDR_TIMEOUT, 16'h0002);
        client_u.release_bus(1);
        for (n = 1; n < 100 && drop !== 1'b1; n++)
            @(negedge clk_sys_in);
        chk("idle drop delay", 32'h1, {31'h0, n >= 4 && n <= 13});
        chk("dropped id", 32'h6, {29'h0, drop_id});
        client_u.release_bus(1);
        chk("auth", 32'h00, {24'h0, auth});
        stop_test();
    end
endmodule : test_gateway_status_connection_control
`default_nettype wire
